// ### pkg/cfgio_regs.vh
/*
  Constants for the configurable I/O port bank: register offsets inside the
  I/O register space, reset values, field masks and bus-type encodings.
  Assumes the host decodes the I/O register space and presents an 8-bit offset.
*/
`ifndef CFGIO_REGS_VH
`define CFGIO_REGS_VH

// Port base offsets
`define CFGIO_PORT_A       8'h00
`define CFGIO_PORT_B       8'h01
`define CFGIO_PORT_C       8'h10
`define CFGIO_PORT_D       8'h11

// Register offsets added to a port base
`define CFGIO_OFS_PIN_IN   8'h00
`define CFGIO_OFS_MODE     8'h02
`define CFGIO_OFS_OUT      8'h04
`define CFGIO_OFS_DIR      8'h06
`define CFGIO_OFS_DRIVE    8'h08

// Reset values
`define CFGIO_RST_CFG      8'h00
`define CFGIO_RST_OUT      8'h00

// Field masks
`define CFGIO_OD_MASK_AB   8'hF0
`define CFGIO_SLEW_MASK_AB 8'h0F
`define CFGIO_OD_MASK_C    8'hFF
`define CFGIO_SLEW_MASK_D  3'h7

// Host bus type encodings
`define CFGIO_BUS_MUX      2'h0
`define CFGIO_BUS_PAGED    2'h1
`define CFGIO_BUS_WIDE8    2'h2
`define CFGIO_BUS_NONMUX   2'h3

`endif

// ### hdl/cfgio_pin_port.v
/*
  One I/O port: per-pin output multiplexer, driver enable, open-drain and
  slew selection. Assumes registers and address lanes come from the bank.
*/
`timescale 1ns/10ps
module cfgio_pin_port #(
  parameter       W         = 8,
  parameter [7:0] MODE_MASK = 8'hFF,
  parameter [7:0] OD_MASK   = 8'hF0,
  parameter [7:0] SLEW_MASK = 8'h0F
) (
  input  wire [W-1:0] dataOut,   // Output latch
  input  wire [W-1:0] dir,       // Direction bits
  input  wire [W-1:0] mode,      // Mode-select bits
  input  wire [W-1:0] drive,     // Drive-style bits
  input  wire [W-1:0] addrLane,  // Latched or live address for this port
  input  wire [W-1:0] addrValid, // Lanes carrying address
  input  wire [W-1:0] logicSel,  // Pin assigned to logic output
  input  wire [W-1:0] logicOut,  // Logic array output value
  input  wire [W-1:0] logicOe,   // Logic output-enable term
  output reg  [W-1:0] pinOut,    // Pin output value
  output reg  [W-1:0] pinOe,     // Pin output enable
  output wire [W-1:0] fastSlew   // Fast slew select
);
  wire [W-1:0] modeEff = mode & MODE_MASK[W-1:0];
  wire [W-1:0] odEff   = drive & OD_MASK[W-1:0];
  integer i;

  assign fastSlew = drive & SLEW_MASK[W-1:0];

  always @* begin
    pinOut = {W{1'b0}};
    pinOe  = {W{1'b0}};
    for (i = 0; i < W; i = i + 1) begin
      if (logicSel[i]) begin
        pinOut[i] = logicOut[i];
      end else if (modeEff[i] && addrValid[i] && (dir[i] || logicOe[i])) begin
        pinOut[i] = addrLane[i];
      end else begin
        pinOut[i] = dataOut[i];
      end
      // Open drain only ever pulls low; a high level is left to the pull-up
      pinOe[i] = (dir[i] || logicOe[i]) && !(odEff[i] && pinOut[i]);
    end
  end
endmodule

// ### hdl/cfgio_port_bank.v
/*
  Configurable I/O port bank: ports A, B, C (8 pins) and D (3 pins) with
  their configuration and data registers, address latch, address lanes
  and data-port override. Assumes the host strobes are synchronous to
  clock and already decoded to the I/O register space by ioSelect.
*/
`timescale 1ns/10ps
`include "cfgio_regs.vh"
module cfgio_port_bank #(
  parameter AW = 16
) (
  input  wire          clock,        // 125 MHz clock
  input  wire          rst_n,        // Asynchronous reset, active low
  input  wire          ioSelect,     // Access targets the I/O register space
  input  wire [7:0]    regAddr,      // Offset inside the I/O register space
  input  wire          wrStrobe,     // Register write request
  input  wire          rdStrobe,     // Register read request
  input  wire [7:0]    wrData,       // Write data
  output reg  [7:0]    rdData,       // Read data, valid cycle after rdStrobe
  output reg           rdValid,      // Read data valid pulse
  input  wire          addrStrobe,   // Address latch strobe, active high
  input  wire [AW-1:0] hostAddr,     // Host address bus
  input  wire [1:0]    busType,      // Host bus type selection
  input  wire          dataPortEn,   // Port A serves as host data bus
  input  wire [7:0]    hostDataOut,  // Data to host in data-port mode
  input  wire          hostDataOe,   // Host read cycle in data-port mode
  output wire [7:0]    hostDataIn,   // Host data seen on port A
  input  wire [7:0]    pinInA,       // Port A pin levels
  output wire [7:0]    pinOutA,      // Port A output value
  output wire [7:0]    pinOeA,       // Port A output enable
  output wire [7:0]    fastSlewA,    // Port A fast slew
  input  wire [7:0]    pinInB,       // Port B pin levels
  output wire [7:0]    pinOutB,      // Port B output value
  output wire [7:0]    pinOeB,       // Port B output enable
  output wire [7:0]    fastSlewB,    // Port B fast slew
  input  wire [7:0]    pinInC,       // Port C pin levels
  output wire [7:0]    pinOutC,      // Port C output value
  output wire [7:0]    pinOeC,       // Port C output enable
  input  wire [2:0]    pinInD,       // Port D pin levels
  output wire [2:0]    pinOutD,      // Port D output value
  output wire [2:0]    pinOeD,       // Port D output enable
  output wire [2:0]    fastSlewD,    // Port D fast slew
  input  wire [7:0]    logicSelA,    // Port A pins on logic outputs
  input  wire [7:0]    logicOutA,    // Port A logic outputs
  input  wire [7:0]    logicOeA,     // Port A logic output enables
  input  wire [7:0]    logicSelB,    // Port B pins on logic outputs
  input  wire [7:0]    logicOutB,    // Port B logic outputs
  input  wire [7:0]    logicOeB,     // Port B logic output enables
  input  wire [7:0]    logicOeC,     // Port C output-enable terms
  input  wire [2:0]    logicSelD,    // Port D pins on logic outputs
  input  wire [2:0]    logicOutD,    // Port D logic outputs
  input  wire [2:0]    logicOeD,     // Port D logic output enables
  output reg  [7:0]    addrInA,      // Port A captured address inputs
  output reg  [7:0]    addrInB,      // Port B captured address inputs
  output reg  [7:0]    addrInC,      // Port C captured address inputs
  output reg  [2:0]    addrInD       // Port D captured address inputs
);

  function hit;
    input [7:0] addr;
    input [7:0] base;
    input [7:0] ofs;
    begin
      hit = (addr == (base + ofs));
    end
  endfunction

  // Configuration and data registers
  reg [7:0] modeA;
  reg [7:0] modeB;
  reg [7:0] dirA;
  reg [7:0] dirB;
  reg [7:0] dirC;
  reg [2:0] dirD;
  reg [7:0] driveA;
  reg [7:0] driveB;
  reg [7:0] driveC;
  reg [2:0] driveD;
  reg [7:0] outA;
  reg [7:0] outB;
  reg [7:0] outC;
  reg [2:0] outD;
  reg [15:0] latchedAddr;

  wire wrEn = ioSelect && wrStrobe;
  wire rdEn = ioSelect && rdStrobe;

  // Register writes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      modeA  <= `CFGIO_RST_CFG;
      modeB  <= `CFGIO_RST_CFG;
      dirA   <= `CFGIO_RST_CFG;
      dirB   <= `CFGIO_RST_CFG;
      dirC   <= `CFGIO_RST_CFG;
      dirD   <= 3'h0;
      driveA <= `CFGIO_RST_CFG;
      driveB <= `CFGIO_RST_CFG;
      driveC <= `CFGIO_RST_CFG;
      driveD <= 3'h0;
      outA   <= `CFGIO_RST_OUT;
      outB   <= `CFGIO_RST_OUT;
      outC   <= `CFGIO_RST_OUT;
      outD   <= 3'h0;
    end else if (wrEn) begin
      if (hit(regAddr, `CFGIO_PORT_A, `CFGIO_OFS_MODE)) begin
        modeA <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_B, `CFGIO_OFS_MODE)) begin
        modeB <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_A, `CFGIO_OFS_DIR)) begin
        dirA <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_B, `CFGIO_OFS_DIR)) begin
        dirB <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_C, `CFGIO_OFS_DIR)) begin
        dirC <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_D, `CFGIO_OFS_DIR)) begin
        dirD <= wrData[2:0];
      end
      if (hit(regAddr, `CFGIO_PORT_A, `CFGIO_OFS_DRIVE)) begin
        driveA <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_B, `CFGIO_OFS_DRIVE)) begin
        driveB <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_C, `CFGIO_OFS_DRIVE)) begin
        driveC <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_D, `CFGIO_OFS_DRIVE)) begin
        driveD <= wrData[2:0];
      end
      if (hit(regAddr, `CFGIO_PORT_A, `CFGIO_OFS_OUT)) begin
        outA <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_B, `CFGIO_OFS_OUT)) begin
        outB <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_C, `CFGIO_OFS_OUT)) begin
        outC <= wrData;
      end
      if (hit(regAddr, `CFGIO_PORT_D, `CFGIO_OFS_OUT)) begin
        outD <= wrData[2:0];
      end
    end
  end

  // Read-back mux; unmapped offsets and absent bits read as zero
  reg [7:0] next_rdData;
  always @* begin
    next_rdData = 8'h00;
    case (1'b1)
      hit(regAddr, `CFGIO_PORT_A, `CFGIO_OFS_PIN_IN): next_rdData = pinInA;
      hit(regAddr, `CFGIO_PORT_B, `CFGIO_OFS_PIN_IN): next_rdData = pinInB;
      hit(regAddr, `CFGIO_PORT_C, `CFGIO_OFS_PIN_IN): next_rdData = pinInC;
      hit(regAddr, `CFGIO_PORT_D, `CFGIO_OFS_PIN_IN): next_rdData = {5'h00, pinInD};
      hit(regAddr, `CFGIO_PORT_A, `CFGIO_OFS_MODE):   next_rdData = modeA;
      hit(regAddr, `CFGIO_PORT_B, `CFGIO_OFS_MODE):   next_rdData = modeB;
      hit(regAddr, `CFGIO_PORT_A, `CFGIO_OFS_DIR):    next_rdData = dirA;
      hit(regAddr, `CFGIO_PORT_B, `CFGIO_OFS_DIR):    next_rdData = dirB;
      hit(regAddr, `CFGIO_PORT_C, `CFGIO_OFS_DIR):    next_rdData = dirC;
      hit(regAddr, `CFGIO_PORT_D, `CFGIO_OFS_DIR):    next_rdData = {5'h00, dirD};
      hit(regAddr, `CFGIO_PORT_A, `CFGIO_OFS_DRIVE):  next_rdData = driveA;
      hit(regAddr, `CFGIO_PORT_B, `CFGIO_OFS_DRIVE):  next_rdData = driveB;
      hit(regAddr, `CFGIO_PORT_C, `CFGIO_OFS_DRIVE):  next_rdData = driveC;
      hit(regAddr, `CFGIO_PORT_D, `CFGIO_OFS_DRIVE):  next_rdData = {5'h00, driveD};
      hit(regAddr, `CFGIO_PORT_A, `CFGIO_OFS_OUT):    next_rdData = outA;
      hit(regAddr, `CFGIO_PORT_B, `CFGIO_OFS_OUT):    next_rdData = outB;
      hit(regAddr, `CFGIO_PORT_C, `CFGIO_OFS_OUT):    next_rdData = outC;
      hit(regAddr, `CFGIO_PORT_D, `CFGIO_OFS_OUT):    next_rdData = {5'h00, outD};
      default: next_rdData = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData  <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdEn;
      if (rdEn) begin
        rdData <= next_rdData;
      end
    end
  end

  // Address latch and address-input capture on the strobe
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latchedAddr <= 16'h0000;
      addrInA     <= 8'h00;
      addrInB     <= 8'h00;
      addrInC     <= 8'h00;
      addrInD     <= 3'h0;
    end else if (addrStrobe) begin
      latchedAddr <= hostAddr[15:0];
      addrInA     <= pinInA;
      addrInB     <= pinInB;
      addrInC     <= pinInC;
      addrInD     <= pinInD;
    end
  end

  // Address lanes per bus type; lanes not listed fall back to the output latch
  reg [7:0] laneA;
  reg [7:0] laneB;
  reg [7:0] validA;
  reg [7:0] validB;
  always @* begin
    laneA  = 8'h00;
    laneB  = 8'h00;
    validA = 8'h00;
    validB = 8'h00;
    case (busType)
      `CFGIO_BUS_MUX: begin
        laneA  = latchedAddr[7:0];
        laneB  = latchedAddr[7:0];
        validA = 8'hFF;
        validB = 8'hFF;
      end
      `CFGIO_BUS_PAGED: begin
        laneB  = latchedAddr[15:8];
        validB = 8'hFF;
      end
      `CFGIO_BUS_WIDE8: begin
        laneA  = {latchedAddr[7:4], 4'h0};
        laneB  = {4'h0, latchedAddr[11:8]};
        validA = 8'hF0;
        validB = 8'h0F;
      end
      `CFGIO_BUS_NONMUX: begin
        // No strobe on this bus type: the address is taken live
        laneB  = hostAddr[7:0];
        validB = 8'hFF;
      end
      default: begin
        laneA  = 8'h00;
        laneB  = 8'h00;
      end
    endcase
  end

  // Data-port mode takes port A value and enable from hostDataOut and hostDataOe; fastSlewA still follows driveA
  wire [7:0] portOutA;
  wire [7:0] portOeA;
  assign hostDataIn = pinInA;
  assign pinOutA    = dataPortEn ? hostDataOut : portOutA;
  assign pinOeA     = dataPortEn ? {8{hostDataOe}} : portOeA;

  cfgio_pin_port #(
    .W         (8),
    .MODE_MASK (8'hFF),
    .OD_MASK   (`CFGIO_OD_MASK_AB),
    .SLEW_MASK (`CFGIO_SLEW_MASK_AB)
  ) uPortA (
    .dataOut   (outA),
    .dir       (dirA),
    .mode      (modeA),
    .drive     (driveA),
    .addrLane  (laneA),
    .addrValid (validA),
    .logicSel  (logicSelA),
    .logicOut  (logicOutA),
    .logicOe   (logicOeA),
    .pinOut    (portOutA),
    .pinOe     (portOeA),
    .fastSlew  (fastSlewA)
  );

  cfgio_pin_port #(
    .W         (8),
    .MODE_MASK (8'hFF),
    .OD_MASK   (`CFGIO_OD_MASK_AB),
    .SLEW_MASK (`CFGIO_SLEW_MASK_AB)
  ) uPortB (
    .dataOut   (outB),
    .dir       (dirB),
    .mode      (modeB),
    .drive     (driveB),
    .addrLane  (laneB),
    .addrValid (validB),
    .logicSel  (logicSelB),
    .logicOut  (logicOutB),
    .logicOe   (logicOeB),
    .pinOut    (pinOutB),
    .pinOe     (pinOeB),
    .fastSlew  (fastSlewB)
  );

  // Port C has no mode register and no logic outputs
  cfgio_pin_port #(
    .W         (8),
    .MODE_MASK (8'h00),
    .OD_MASK   (`CFGIO_OD_MASK_C),
    .SLEW_MASK (8'h00)
  ) uPortC (
    .dataOut   (outC),
    .dir       (dirC),
    .mode      (8'h00),
    .drive     (driveC),
    .addrLane  (8'h00),
    .addrValid (8'h00),
    .logicSel  (8'h00),
    .logicOut  (8'h00),
    .logicOe   (logicOeC),
    .pinOut    (pinOutC),
    .pinOe     (pinOeC),
    .fastSlew  ()
  );

  cfgio_pin_port #(
    .W         (3),
    .MODE_MASK (8'h00),
    .OD_MASK   (8'h00),
    .SLEW_MASK ({5'h00, `CFGIO_SLEW_MASK_D})
  ) uPortD (
    .dataOut   (outD),
    .dir       (dirD),
    .mode      (3'h0),
    .drive     (driveD),
    .addrLane  (3'h0),
    .addrValid (3'h0),
    .logicSel  (logicSelD),
    .logicOut  (logicOutD),
    .logicOe   (logicOeD),
    .pinOut    (pinOutD),
    .pinOe     (pinOeD),
    .fastSlew  (fastSlewD)
  );

endmodule

// ### testbench/cfgio_host_model.sv
/*
  Host model for the port bank register bus: single writes and reads.
  Assumes strobes are taken on the rising clock edge, read data a cycle later.
*/
`timescale 1ns/10ps
module cfgio_host_model (
  input  wire       clock,    // Clock
  output logic      ioSelect, // I/O space select
  output logic [7:0] regAddr, // Offset
  output logic      wrStrobe, // Write request
  output logic      rdStrobe, // Read request
  output logic [7:0] wrData,  // Write data
  input  wire [7:0] rdData,   // Read data
  input  wire       rdValid   // Read data valid
);
  initial begin
    ioSelect = 1'h0;
    regAddr = 8'h00;
    wrStrobe = 1'h0;
    rdStrobe = 1'h0;
    wrData = 8'h00;
  end

  // Released lines show inverted values so stale data is never mistaken for valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    ioSelect <= 1'h1;
    regAddr <= a;
    wrData <= d;
    wrStrobe <= 1'h1;
    @(posedge clock);
    ioSelect <= 1'h0;
    wrStrobe <= 1'h0;
    wrData <= ~d;
    regAddr <= ~a;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    ioSelect <= 1'h1;
    regAddr <= a;
    rdStrobe <= 1'h1;
    @(posedge clock);
    ioSelect <= 1'h0;
    rdStrobe <= 1'h0;
    regAddr <= ~a;
    d = 'x;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      if (rdValid === 1'h1) begin
        d = rdData;
        break;
      end
    end
  endtask
endmodule

// ### testbench/cfgio_monitor.sv
/*
  Assertions on the port bank top ports.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/10ps
module cfgio_monitor (
  input wire       clock,       // Clock
  input wire       rst_n,       // Reset, active low
  input wire       ioSelect,    // I/O space select
  input wire       wrStrobe,    // Write
  input wire       rdStrobe,    // Read
  input wire [7:0] regAddr,     // Offset
  input wire [7:0] wrData,      // Write data
  input wire       rdValid,     // Read valid
  input wire       addrStrobe,  // Address strobe
  input wire [7:0] pinInA,      // Port A pins
  input wire [7:0] addrInA,     // Port A capture
  input wire [2:0] addrInD,     // Port D capture
  input wire [7:0] fastSlewA,   // Port A slew
  input wire [2:0] pinOeD,      // Port D enable
  input wire [2:0] logicOeD,    // Port D logic enable
  input wire [7:0] pinOeC,      // Port C enable
  input wire [7:0] logicOeC,    // Port C logic enable
  input wire       dataPortEn,  // Data port mode
  input wire       hostDataOe,  // Data port drive
  input wire [7:0] hostDataOut, // Data port value
  input wire [7:0] pinOutA,     // Port A value
  input wire [7:0] pinOeA       // Port A enable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_READ_ANSWER: assert property (ioSelect && rdStrobe |=> rdValid)
    else $error("read not answered");
  AST_READ_QUIET: assert property (!(ioSelect && rdStrobe) |=> !rdValid)
    else $error("read valid without read");
  AST_SLEW_WRITE: assert property (ioSelect && wrStrobe && regAddr == 8'h08 |=>
    fastSlewA == ($past(wrData) & 8'h0F)) else $error("port A slew wrong");
  AST_DIR_D: assert property (ioSelect && wrStrobe && regAddr == 8'h17 |=>
    {5'h00, pinOeD} == (($past(wrData) & 8'h07) | {5'h00, logicOeD}))
    else $error("port D enable wrong");
  AST_RESET_C: assert property ($rose(rst_n) |-> pinOeC == logicOeC)
    else $error("port C enable after reset");
  AST_CAPTURE: assert property (addrStrobe |=> addrInA == $past(pinInA))
    else $error("address input not captured");
  AST_CAPTURE_HOLD: assert property (!addrStrobe |=> $stable(addrInD))
    else $error("address input moved");
  AST_DATA_PORT: assert property (dataPortEn && hostDataOe |->
    pinOutA == hostDataOut && pinOeA == 8'hFF) else $error("data port not driven");

  cover property (ioSelect && rdStrobe);
  cover property (addrStrobe);
  cover property (dataPortEn && hostDataOe);
endmodule

bind cfgio_port_bank cfgio_monitor u_mon (.clock, .rst_n, .ioSelect, .wrStrobe, .rdStrobe,
  .regAddr, .wrData, .rdValid, .addrStrobe, .pinInA, .addrInA, .addrInD, .fastSlewA,
  .pinOeD, .logicOeD, .pinOeC, .logicOeC, .dataPortEn, .hostDataOe, .hostDataOut,
  .pinOutA, .pinOeA);

// ### testbench/testbench.sv
/*
  Self-checking bench: host model on the register bus, an integer model of
  the registers, random pins, address and logic traffic.
  Assumes the monitor binds itself to the port bank.
*/
`timescale 1ns/10ps
module testbench;
  logic        clock;
  logic        rst_n;
  logic        addrStrobe, dataPortEn, hostDataOe;
  logic [15:0] hostAddr;
  logic [1:0]  busType;
  logic [7:0]  hostDataOut, logicSelA, logicOutA, logicOeA, logicSelB, logicOutB, logicOeB;
  logic [7:0]  logicOeC, pv [4];
  logic [2:0]  logicSelD, logicOutD, logicOeD;
  wire         ioSelect, wrStrobe, rdStrobe, rdValid;
  wire  [7:0]  regAddr, wrData, rdData, hostDataIn, pinOutA, pinOeA, fastSlewA, pinOutB;
  wire  [7:0]  pinOeB, fastSlewB, pinOutC, pinOeC, addrInA, addrInB, addrInC;
  wire  [2:0]  pinOutD, pinOeD, fastSlewD, addrInD;
  wire  [7:0]  pinInA = pv[0], pinInB = pv[1], pinInC = pv[2];
  wire  [2:0]  pinInD = pv[3][2:0];
  wire  [7:0]  oe [4], po [4], fs [4];
  int          m [4][5];
  int          od [4] = '{8'hF0, 8'hF0, 8'hFF, 8'h00};
  int          sl [4] = '{8'h0F, 8'h0F, 8'h00, 8'h07};
  int          errors, samples_checked;
  logic [31:0] rnd;
  logic [7:0]  d, eA, eB;

  assign oe = '{pinOeA, pinOeB, pinOeC, {5'h00, pinOeD}};
  assign po = '{pinOutA, pinOutB, pinOutC, {5'h00, pinOutD}};
  assign fs = '{fastSlewA, fastSlewB, 8'h00, {5'h00, fastSlewD}};

  cfgio_host_model u_host (.clock, .ioSelect, .regAddr, .wrStrobe, .rdStrobe, .wrData,
    .rdData, .rdValid);
  cfgio_port_bank u_dut (.clock, .rst_n, .ioSelect, .regAddr, .wrStrobe, .rdStrobe, .wrData,
    .rdData, .rdValid, .addrStrobe, .hostAddr, .busType, .dataPortEn, .hostDataOut,
    .hostDataOe, .hostDataIn, .pinInA, .pinOutA, .pinOeA, .fastSlewA, .pinInB, .pinOutB,
    .pinOeB, .fastSlewB, .pinInC, .pinOutC, .pinOeC, .pinInD, .pinOutD, .pinOeD, .fastSlewD,
    .logicSelA, .logicOutA, .logicOeA, .logicSelB, .logicOutB, .logicOeB, .logicOeC,
    .logicSelD, .logicOutD, .logicOeD, .addrInA, .addrInB, .addrInC, .addrInD);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ra(input int p, input int r);
    return {3'h0, p[1], 3'h0, p[0]} + 8'(2 * r);
  endfunction
  // Ports C and D have no mode register; port D has three pins
  function automatic int msk(input int p, input int r);
    return (r == 1 && p > 1) ? 8'h00 : (p == 3 ? 8'h07 : 8'hFF);
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdChk(input int p, input int r, input logic [7:0] e);
    u_host.rd(ra(p, r), d);
    chk("register read", e, d);
  endtask
  task automatic w(input int p, input int r, input int v);
    u_host.wr(ra(p, r), 8'(v));
    m[p][r] = v & msk(p, r);
  endtask
  task automatic pins();
    @(negedge clock);
    for (int p = 0; p < 4; p++) begin
      chk("pin enable", 8'(m[p][3] & ~(m[p][4] & od[p] & m[p][2])), oe[p]);
      chk("pin value", 8'(m[p][2]), po[p]);
      chk("fast slew", 8'(m[p][4] & sl[p]), fs[p]);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    close_out();
  end

  initial begin
    rnd = 32'hF39670A9;
    {rst_n, addrStrobe, dataPortEn, hostDataOe, hostAddr, busType, hostDataOut} = 'h0;
    {logicSelA, logicOutA, logicOeA, logicSelB, logicOutB, logicOeB, logicOeC} = 'h0;
    {logicSelD, logicOutD, logicOeD} = 'h0;
    pv = '{default: 8'h00};
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    for (int p = 0; p < 4; p++)
      for (int r = 1; r < 5; r++)
        rdChk(p, r, 8'h00);
    pins();
    repeat (3) begin
      for (int p = 0; p < 4; p++)
        for (int r = 1; r < 5; r++) begin
          rnd = lfsr(rnd);
          w(p, r, rnd[7:0]);
        end
      for (int p = 0; p < 4; p++)
        for (int r = 1; r < 5; r++)
          rdChk(p, r, 8'(m[p][r]));
      w(0, 1, 8'h00);
      w(1, 1, 8'h00);
      pins();
    end
    rnd = lfsr(rnd);
    @(posedge clock);
    for (int p = 0; p < 4; p++)
      pv[p] <= rnd[8*p +: 8];
    @(negedge clock);
    for (int p = 0; p < 4; p++)
      rdChk(p, 0, pv[p] & 8'(msk(p, 0)));
    // The host has booted, so address lanes may now be enabled
    for (int p = 0; p < 2; p++) begin
      w(p, 1, 8'hFF);
      w(p, 3, 8'hFF);
      w(p, 4, 8'h00);
    end
    for (int bt = 0; bt < 4; bt++) begin
      rnd = lfsr(rnd);
      @(posedge clock);
      busType <= 2'(bt);
      hostAddr <= rnd[15:0];
      addrStrobe <= 1'h1;
      pv[0] <= rnd[23:16];
      @(posedge clock);
      addrStrobe <= 1'h0;
      @(negedge clock);
      eA = bt == 0 ? hostAddr[7:0] : bt == 2 ? {hostAddr[7:4], 4'(m[0][2])} : 8'(m[0][2]);
      eB = bt == 1 ? hostAddr[15:8] : bt == 2 ? {4'(m[1][2] >> 4), hostAddr[11:8]}
                                              : hostAddr[7:0];
      chk("port A lanes", eA, pinOutA);
      chk("port B lanes", eB, pinOutB);
      chk("address input A", pv[0], addrInA);
      chk("address input B", pv[1], addrInB);
      chk("address input C", pv[2], addrInC);
      chk("address input D", {5'h00, pv[3][2:0]}, {5'h00, addrInD});
    end
    // Logic pins are outputs only, so no direction bit is set for a logic input
    rnd = lfsr(rnd);
    @(posedge clock);
    logicSelA <= rnd[7:0];
    logicOutA <= rnd[15:8];
    logicOeA <= rnd[23:16];
    logicOeC <= rnd[31:24];
    logicSelB <= rnd[15:8];
    logicOutB <= rnd[7:0];
    logicOeD <= rnd[2:0];
    @(negedge clock);
    chk("port A logic", (logicSelA & logicOutA) | (~logicSelA & 8'(m[0][2])), pinOutA);
    chk("port B logic", (logicSelB & logicOutB) | (~logicSelB & hostAddr[7:0]), pinOutB);
    chk("port C enable", 8'((m[2][3] | logicOeC) & ~(m[2][4] & m[2][2])), pinOeC);
    chk("port D enable", 8'(m[3][3] | logicOeD), {5'h00, pinOeD});
    @(posedge clock);
    dataPortEn <= 1'h1;
    hostDataOe <= 1'h1;
    hostDataOut <= rnd[31:24];
    @(negedge clock);
    chk("data port", hostDataOut, pinOutA);
    chk("host data in", pv[0], hostDataIn);
    rdChk(0, 2, 8'(m[0][2]));
    // A host write cycle in data-port mode must leave port A undriven
    @(posedge clock);
    hostDataOe <= 1'h0;
    @(negedge clock);
    chk("data port release", 8'h00, pinOeA);
    // Mid-run reset must clear the configured port C registers again
    @(posedge clock);
    rst_n <= 1'h0;
    dataPortEn <= 1'h0;
    @(posedge clock);
    rst_n <= 1'h1;
    for (int r = 1; r < 5; r++)
      rdChk(2, r, 8'h00);
    close_out();
  end
endmodule
